// ---- core/ssdc_pkg.sv ----
package ssdc_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_FREQ_HZ     = 200_000_000;
   localparam int unsigned TICK_PERIOD_US  = 1000;
   localparam int unsigned TICK_CYCLES_DEF = (CLK_FREQ_HZ / 1_000_000) * TICK_PERIOD_US;
   // Backup drop bound beyond the set delay
   localparam logic [27:0] GRACE_MS        = 28'h000_0014;
   localparam logic [27:0] TOL_PCT         = 28'h000_000F;
   localparam logic [27:0] PCT_BASE        = 28'h000_0064;
   // Weight of one rotary switch step in ms
   localparam logic [19:0] LEFT_STEP_MS    = 20'h003E8;
   localparam logic [19:0] RIGHT_STEP_MS   = 20'h003E8;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [31:0] CTRL_OFS        = 32'h0000_0000;
   localparam logic [31:0] STATUS_OFS      = 32'h0000_0004;
   localparam logic [31:0] IRQ_STAT_OFS    = 32'h0000_0008;
   localparam logic [31:0] IRQ_MASK_OFS    = 32'h0000_000C;
   localparam logic [31:0] DELAY_OFS       = 32'h0000_0010;
   localparam logic [31:0] REMAIN_OFS      = 32'h0000_0014;

   // Control fields
   localparam int unsigned CTRL_DUAL_BIT   = 0;
   localparam int unsigned CTRL_MODE_LSB   = 1;
   localparam logic [2:0]  CTRL_RESET      = 3'h4;
   localparam logic [1:0]  MODE_AUTO       = 2'h0;
   localparam logic [1:0]  MODE_MANUAL     = 2'h1;

   // Status fields
   localparam int unsigned ST_ACTIVE       = 0;
   localparam int unsigned ST_READY        = 1;
   localparam int unsigned ST_DELAYED      = 2;
   localparam int unsigned ST_FUSE         = 3;
   localparam int unsigned ST_EARTH        = 4;
   localparam int unsigned ST_SHORT        = 5;
   localparam int unsigned ST_CROSS        = 6;
   localparam int unsigned ST_EXP          = 7;
   localparam int unsigned ST_ARMED        = 8;

   // Interrupt events
   localparam int unsigned IRQ_W           = 5;
   localparam int unsigned EV_ACTIVATE     = 0;
   localparam int unsigned EV_DEACTIVATE   = 1;
   localparam int unsigned EV_EXPIRE       = 2;
   localparam int unsigned EV_FAULT        = 3;
   localparam int unsigned EV_BACKUP       = 4;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARMED_WAIT,
      ST_ON
   } ssdc_state_e;

   typedef struct packed {
      logic       supplyPresent;
      logic       channelOne;
      logic       channelTwo;
      logic       startCircuit;
      logic       feedbackLoop;
      logic       crossShortTestA;
      logic       crossShortTestB;
      logic       earthFaultStart;
      logic       earthFaultInput;
      logic       inputShort;
      logic [3:0] instExpFault;
      logic [3:0] delayExpFault;
      logic [3:0] rotaryLeft;
      logic [3:0] rotaryRight;
   } ssdc_pins_s;

   localparam int unsigned PIN_W = $bits(ssdc_pins_s);

   typedef struct packed {
      logic supplyIndicator;
      logic channelOneIndicator;
      logic channelTwoIndicator;
      logic outputIndicator;
      logic startIndicator;
      logic faultIndicator;
      logic instEnable;
      logic delayEnable;
      logic switchStateOutput;
      logic supplyFaultOutput;
   } ssdc_out_s;

endpackage : ssdc_pkg

// ---- core/ssdc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module ssdc_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] din,
   output var  logic [WIDTH-1:0] dout
);

   // ************************************************************
   // Two-stage synchroniser per bit
   // ************************************************************
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         logic meta_q;
         always_ff @(posedge clk) begin
            if (!nrst) begin
               meta_q  <= 1'b0;
               dout[i] <= 1'b0;
            end else begin
               meta_q  <= din[i];
               dout[i] <= meta_q;
            end
         end
      end
   endgenerate

endmodule : ssdc_sync

`default_nettype wire

// ---- core/ssdc_top.sv ----
// Functional notes
// - Ready needs feedback loop and start circuit closed, and the start indicator shows it.
// - On activation both channel lamps and output lamp light, instant enable and switch state go high, start lamp off.
// - When the input opens, channel lamps, output lamp, instant enable and switch state drop at once.
// - After the input opens the delayed enable stays high until the set delay expires.
// - Supply/fault output is high with supply and intact fuse, low on any own or expansion fault.
// - Expansion delays add on top of this unit's delay, so this unit adds nothing of its own.
// - Single channel runs without redundancy but still checks earth faults on start and input.
// - Dual channel uses both channels and checks earth faults, input shorts and cross shorts.
// - Automatic start activates as soon as the input closes.
// - Manual start activates only while input and start circuit are both closed.
// - Monitored start activates after a close then open of the start circuit with the input closed.
// - A backup counter drops the delayed enable by set delay plus 20 ms plus 15 percent.
// - The bus serves up to four instant and four delayed expansion modules.
// - A short between the cross-short test inputs while active blows the fuse until reset.
// - Delay time is the sum of the two rotary switch values.
`timescale 1ns/1ps
`default_nettype none

module ssdc_top #(
   parameter int unsigned TICK_CYCLES = ssdc_pkg::TICK_CYCLES_DEF
) (
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output var  logic [31:0]          prdata,
   output var  logic                 pready,
   output var  logic                 pslverr,
   output var  logic                 irq,
   input  wire ssdc_pkg::ssdc_pins_s pins,
   output var  ssdc_pkg::ssdc_out_s  outs
);
   import ssdc_pkg::*;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic isReg(input logic [31:0] addr, input logic [31:0] ofs);
      isReg = (addr == ofs);
   endfunction : isReg

   function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = wdat[b*8 +: 8];
         end
      end
      mergeStrb = res;
   endfunction : mergeStrb

   // ************************************************************
   // Pin synchronisation
   // ************************************************************
   logic [PIN_W-1:0] pinBits;
   ssdc_pins_s       pin;

   ssdc_sync #(
      .WIDTH (PIN_W)
   ) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .din  (pins),
      .dout (pinBits)
   );

   assign pin = ssdc_pins_s'(pinBits);

   // ************************************************************
   // Registers and bus
   // ************************************************************
   logic [2:0]       ctrl_q;
   logic [IRQ_W-1:0] irqStat_q;
   logic [IRQ_W-1:0] irqMask_q;
   logic [IRQ_W-1:0] events;
   logic [31:0]      rdData;
   logic             addrHit;
   logic             wrAccess;
   logic             dualMode;
   logic [1:0]       startMode;
   logic [31:0]      ctrlNew;
   logic [31:0]      w1c;

   assign dualMode  = ctrl_q[CTRL_DUAL_BIT];
   assign startMode = ctrl_q[CTRL_MODE_LSB +: 2];
   assign wrAccess  = psel && penable && pwrite;
   assign pready    = 1'b1;
   assign ctrlNew   = mergeStrb({29'h0000_0000, ctrl_q}, pwdata, pstrb);
   assign w1c       = mergeStrb(32'h0000_0000, pwdata, pstrb);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctrl_q <= CTRL_RESET;
      end else if (wrAccess && isReg(paddr, CTRL_OFS)) begin
         ctrl_q <= ctrlNew[2:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         irqMask_q <= '0;
      end else if (wrAccess && isReg(paddr, IRQ_MASK_OFS)) begin
         irqMask_q <= IRQ_W'(mergeStrb({27'h000_0000, irqMask_q}, pwdata, pstrb));
      end
   end

   // New events win over a same-cycle clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         irqStat_q <= '0;
      end else if (wrAccess && isReg(paddr, IRQ_STAT_OFS)) begin
         irqStat_q <= (irqStat_q & ~w1c[IRQ_W-1:0]) | events;
      end else begin
         irqStat_q <= irqStat_q | events;
      end
   end

   assign irq = |(irqStat_q & irqMask_q);

   // ************************************************************
   // Fault detection
   // ************************************************************
   ssdc_state_e state_q;
   ssdc_state_e state_d;
   logic        fuseBlown_q;
   logic        earthFault;
   logic        inputShortFault;
   logic        crossShort;
   logic        expFault;
   logic        anyFault;
   logic        fault_q;

   assign earthFault      = pin.earthFaultStart || pin.earthFaultInput;
   assign inputShortFault = dualMode && pin.inputShort;
   assign crossShort      = dualMode && (pin.crossShortTestA == pin.crossShortTestB);
   // four instant and four delayed modules
   assign expFault        = (|pin.instExpFault) || (|pin.delayExpFault);
   assign anyFault        = earthFault || inputShortFault || fuseBlown_q || expFault;

   // cross short while active blows fuse
   always_ff @(posedge clk) begin
      if (!nrst) begin
         fuseBlown_q <= 1'b0;
      end else if (crossShort && (state_q == ST_ON)) begin
         fuseBlown_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= anyFault;
      end
   end

   // ************************************************************
   // Start logic
   // ************************************************************
   logic inputClosed;
   logic ready;

   assign inputClosed = dualMode ? (pin.channelOne && pin.channelTwo) : pin.channelOne;
   // ready when feedback and start closed
   assign ready       = pin.feedbackLoop && pin.startCircuit && !anyFault && pin.supplyPresent;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (startMode == MODE_AUTO) begin
               if (inputClosed && pin.feedbackLoop && !anyFault && pin.supplyPresent) begin
                  state_d = ST_ON;
               end
            end else if (startMode == MODE_MANUAL) begin
               if (inputClosed && ready) begin
                  state_d = ST_ON;
               end
            end else if (inputClosed && ready) begin
               state_d = ST_ARMED_WAIT;
            end
         end
         ST_ARMED_WAIT: begin
            if (!inputClosed || anyFault || !pin.supplyPresent) begin
               state_d = ST_IDLE;
            end else if (!pin.startCircuit) begin
               state_d = ST_ON;
            end
         end
         ST_ON: begin
            if (!inputClosed || anyFault || !pin.supplyPresent) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ************************************************************
   // Delay timer
   // ************************************************************
   logic [31:0] tickCnt_q;
   logic        tick;
   logic [19:0] delayMs;
   logic [27:0] guardMs;
   logic [19:0] remain_q;
   logic [27:0] backup_q;
   logic        delayEn_q;
   logic        counting;
   logic        normalDrop;
   logic        backupDrop;
   logic        activateEv;
   logic        deactEv;

   assign tick = (tickCnt_q == 32'(TICK_CYCLES - 1));

   always_ff @(posedge clk) begin
      if (!nrst || tick) begin
         tickCnt_q <= 32'h0000_0000;
      end else begin
         tickCnt_q <= tickCnt_q + 32'h0000_0001;
      end
   end

   assign delayMs = 20'(pin.rotaryLeft * LEFT_STEP_MS) + 20'(pin.rotaryRight * RIGHT_STEP_MS);
   // backup bound delay plus 20 ms plus 15 percent
   assign guardMs = 28'(delayMs) + GRACE_MS + ((28'(delayMs) * TOL_PCT) / PCT_BASE);

   assign activateEv = (state_q != ST_ON) && (state_d == ST_ON);
   assign deactEv    = (state_q == ST_ON) && (state_d != ST_ON);
   assign counting   = delayEn_q && (state_q != ST_ON) && !deactEv;
   assign normalDrop = counting && (remain_q == 20'h00000);
   assign backupDrop = counting && (backup_q >= guardMs) && !normalDrop;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         delayEn_q <= 1'b0;
         remain_q  <= 20'h00000;
         backup_q  <= 28'h000_0000;
      end else if (fuseBlown_q) begin
         delayEn_q <= 1'b0;
      end else if (activateEv) begin
         // rises with instant enable, delay restarts
         delayEn_q <= 1'b1;
      end else if (deactEv) begin
         remain_q  <= delayMs;
         backup_q  <= 28'h000_0000;
      end else if (normalDrop || backupDrop) begin
         // drop on expiry or backup bound
         delayEn_q <= 1'b0;
      end else if (counting && tick) begin
         remain_q  <= remain_q - 20'h00001;
         backup_q  <= backup_q + 28'h000_0001;
      end
   end

   always_comb begin
      events                = '0;
      events[EV_ACTIVATE]   = activateEv;
      events[EV_DEACTIVATE] = deactEv;
      events[EV_EXPIRE]     = normalDrop && !fuseBlown_q;
      events[EV_FAULT]      = anyFault && !fault_q;
      events[EV_BACKUP]     = backupDrop && !fuseBlown_q;
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   logic active;
   logic chTwoSense;

   assign active     = (state_q == ST_ON);
   assign chTwoSense = dualMode ? pin.channelTwo : pin.channelOne;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         outs <= '0;
      end else begin
         outs.supplyIndicator     <= pin.supplyPresent && !fuseBlown_q;
         outs.channelOneIndicator <= pin.channelOne && !fuseBlown_q;
         outs.channelTwoIndicator <= chTwoSense && !fuseBlown_q;
         outs.outputIndicator     <= active;
         // start lamp while ready and not active
         outs.startIndicator      <= ready && !active;
         outs.faultIndicator      <= anyFault;
         outs.instEnable          <= active;
         outs.switchStateOutput   <= active;
         // delayed enable passes unchanged to modules
         outs.delayEnable         <= delayEn_q;
         // supply present, fuse intact, no fault
         outs.supplyFaultOutput   <= pin.supplyPresent && !anyFault;
      end
   end

   // ************************************************************
   // Read data
   // ************************************************************
   logic [31:0] statusWord;

   always_comb begin
      statusWord              = 32'h0000_0000;
      statusWord[ST_ACTIVE]   = active;
      statusWord[ST_READY]    = ready;
      statusWord[ST_DELAYED]  = delayEn_q;
      statusWord[ST_FUSE]     = fuseBlown_q;
      statusWord[ST_EARTH]    = earthFault;
      statusWord[ST_SHORT]    = inputShortFault;
      statusWord[ST_CROSS]    = crossShort;
      statusWord[ST_EXP]      = expFault;
      statusWord[ST_ARMED]    = (state_q == ST_ARMED_WAIT);
   end

   always_comb begin
      rdData  = 32'h0000_0000;
      addrHit = 1'b1;
      if (isReg(paddr, CTRL_OFS)) begin
         rdData = {29'h0000_0000, ctrl_q};
      end else if (isReg(paddr, STATUS_OFS)) begin
         rdData = statusWord;
      end else if (isReg(paddr, IRQ_STAT_OFS)) begin
         rdData = {27'h000_0000, irqStat_q};
      end else if (isReg(paddr, IRQ_MASK_OFS)) begin
         rdData = {27'h000_0000, irqMask_q};
      end else if (isReg(paddr, DELAY_OFS)) begin
         rdData = {12'h000, delayMs};
      end else if (isReg(paddr, REMAIN_OFS)) begin
         rdData = {12'h000, remain_q};
      end else begin
         addrHit = 1'b0;
      end
   end

   // Answer captured in setup phase, valid through access phase
   always_ff @(posedge clk) begin
      if (!nrst) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata  <= pwrite ? 32'h0000_0000 : rdData;
         pslverr <= !addrHit;
      end
   end

endmodule : ssdc_top

`default_nettype wire

// ---- testbench/ssdc_top_checker.sv ----
`timescale 1ns/1ps
`default_nettype none

module ssdc_top_checker (
   input wire logic                 clk,
   input wire logic                 nrst,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [31:0]          paddr,
   input wire logic [31:0]          pwdata,
   input wire logic [3:0]           pstrb,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire logic                 irq,
   input wire ssdc_pkg::ssdc_pins_s pins,
   input wire ssdc_pkg::ssdc_out_s  outs
);
   import ssdc_pkg::*;

   // ****************************************
   // Output relations
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   chk_switch_state: assert property (outs.switchStateOutput == outs.instEnable)
      else $error("switch state differs from instant enable");
   chk_out_lamp: assert property (outs.outputIndicator == outs.instEnable)
      else $error("output lamp differs from instant enable");
   chk_delay_rise: assert property ($rose(outs.instEnable) |-> outs.delayEnable)
      else $error("delayed enable not raised with instant enable");
   chk_start_lamp: assert property (outs.instEnable |-> !outs.startIndicator)
      else $error("start lamp lit while active");
   chk_input_drop: assert property ((!pins.channelOne) [*7] |-> !outs.instEnable)
      else $error("instant enable held with input open");
   chk_fault_output: assert property (pins.earthFaultInput [*7] |-> !outs.supplyFaultOutput)
      else $error("supply output high during earth fault");
   chk_no_supply: assert property ((!pins.supplyPresent) [*7] |-> !outs.supplyFaultOutput && !outs.instEnable)
      else $error("outputs high without supply");
   chk_delay_hold: assert property ($fell(outs.instEnable) && !pins.crossShortTestA && pins.rotaryLeft != 4'h0
      |-> outs.delayEnable)
      else $error("delayed enable dropped with instant enable");
   chk_ready_resp: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   chk_unmapped_err: assert property (psel && !penable && paddr > REMAIN_OFS ##1 psel && penable |-> pslverr)
      else $error("no error on unmapped address");

   cover property ($rose(outs.instEnable));
   cover property ($fell(outs.delayEnable));
   cover property (pslverr && pready);

endmodule : ssdc_top_checker

bind ssdc_top ssdc_top_checker u_chk (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
                                      .prdata, .pready, .pslverr, .irq, .pins, .outs);

`default_nettype wire

// ---- testbench/ssdc_exp_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module ssdc_exp_model #(
   parameter int unsigned OWN_DELAY = 10
) (
   input  wire logic       clk,
   input  wire logic       instEnable,
   input  wire logic       delayEnable,
   input  wire logic       injectFault,
   output logic            instContact,
   output logic            delayContact,
   output logic [3:0]      instExpFault,
   output logic [3:0]      delayExpFault
);
   int unsigned holdCnt = 0;

   always @(posedge clk) begin
      if (delayEnable) begin
         holdCnt <= OWN_DELAY;
         delayContact <= 1'b1;
      end else if (holdCnt != 0) begin
         holdCnt <= holdCnt - 1;
      end else begin
         delayContact <= 1'b0;
      end
   end

   assign instContact = instEnable;
   assign instExpFault = {3'h0, injectFault};
   assign delayExpFault = {injectFault, 3'h0};

endmodule : ssdc_exp_model

`default_nettype wire

// ---- testbench/safety_start_delay_controller_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module safety_start_delay_controller_bench;
   import ssdc_pkg::*;

   typedef struct packed {logic [1:0] mode; logic ch1; logic st; logic act;} ssdc_row_s;

   logic        clk, nrst, psel, penable, pwrite, pready, pslverr, irq, injectFault;
   logic        delayContact;
   logic [31:0] paddr, pwdata, prdata;
   logic [3:0]  instFault, delayFault;
   ssdc_pins_s  pinsIn, pinsDut;
   ssdc_out_s   outsSeen;
   int          miscompares, checkCount, cycles;
   ssdc_row_s   rows [5] = '{'{2'h0, 1, 0, 1}, '{2'h1, 1, 0, 0}, '{2'h1, 1, 1, 1},
                             '{2'h3, 1, 1, 0}, '{2'h0, 0, 1, 0}};

   assign pinsDut = {pinsIn[25:16], instFault, delayFault, pinsIn[7:0]};

   ssdc_top #(.TICK_CYCLES(4)) dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb(4'hF), .prdata, .pready, .pslverr, .irq, .pins(pinsDut), .outs(outsSeen));

   ssdc_exp_model #(.OWN_DELAY(10)) partner (.clk, .instEnable(outsSeen.instEnable),
      .delayEnable(outsSeen.delayEnable), .injectFault, .instContact(), .delayContact,
      .instExpFault(instFault), .delayExpFault(delayFault));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checkCount++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         miscompares++;
         conclude();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      int n;
      logic [31:0] rd;
      logic er;
      {psel, penable, pwrite, paddr, pwdata, injectFault, cycles} = '0;
      pinsIn = '0;
      pinsIn.supplyPresent = 1'b1;
      pinsIn.feedbackLoop = 1'b1;
      pinsIn.crossShortTestB = 1'b1;
      pinsIn.rotaryLeft = 4'h1;
      pinsIn.rotaryRight = 4'h1;
      nrst = 1'b0;
      tick(2);
      nrst <= 1'b1;
      apb(0, CTRL_OFS, 0, rd, er);
      check(rd, 32'h4, "control reset value");
      foreach (rows[i]) begin
         apb(1, CTRL_OFS, {29'h0, rows[i].mode, 1'b0}, rd, er);
         pinsIn.channelOne <= 1'b0;
         pinsIn.startCircuit <= 1'b0;
         tick(10);
         pinsIn.channelOne <= rows[i].ch1;
         pinsIn.startCircuit <= rows[i].st;
         tick(10);
         check(outsSeen.instEnable, rows[i].act, "start mode enable");
         check(outsSeen.switchStateOutput, rows[i].act, "start mode switch state");
      end
      $display("Test start modes finished");
      pinsIn.channelOne <= 1'b0;
      pinsIn.startCircuit <= 1'b1;
      tick(10);
      check(outsSeen.startIndicator, 1, "ready lamp");
      pinsIn.feedbackLoop <= 1'b0;
      tick(10);
      check(outsSeen.startIndicator, 0, "ready lamp with feedback open");
      pinsIn.feedbackLoop <= 1'b1;
      apb(1, CTRL_OFS, 32'h4, rd, er);
      pinsIn.channelOne <= 1'b1;
      tick(10);
      check(outsSeen.instEnable, 0, "held start");
      pinsIn.startCircuit <= 1'b0;
      tick(10);
      check(outsSeen.instEnable, 1, "start released");
      $display("Test monitored start finished");
      apb(1, CTRL_OFS, 32'h0, rd, er);
      apb(0, DELAY_OFS, 0, rd, er);
      check(rd, 32'h0000_07D0, "delay sum");
      pinsIn.channelOne <= 1'b0;
      tick(10);
      check({outsSeen.instEnable, outsSeen.delayEnable, outsSeen.channelOneIndicator}, 3'b010, "input opened");
      tick(4000);
      pinsIn.channelOne <= 1'b1;
      tick(10);
      check({outsSeen.instEnable, outsSeen.delayEnable}, 2'b11, "reactivated");
      pinsIn.channelOne <= 1'b0;
      n = 0;
      while (outsSeen.delayEnable === 1'b1 && n < 9000) begin
         @(posedge clk);
         n++;
      end
      check(32'(n >= 7990 && n <= 8030), 1, "delay off time");
      check(delayContact, 1, "expansion contact still held");
      tick(12);
      check(delayContact, 0, "expansion contact released");
      $display("Test delay off finished");
      apb(1, IRQ_MASK_OFS, 32'h0, rd, er);
      check(irq, 0, "masked interrupt");
      apb(1, IRQ_MASK_OFS, 32'h4, rd, er);
      tick(1);
      check(irq, 1, "expiry interrupt");
      apb(0, IRQ_STAT_OFS, 0, rd, er);
      check(rd[2:0], 3'h7, "event bits");
      apb(1, IRQ_STAT_OFS, 32'h4, rd, er);
      tick(1);
      check(irq, 0, "interrupt cleared");
      apb(0, 32'h0000_0040, 0, rd, er);
      check({rd, er}, 33'h1, "unmapped read");
      $display("Test registers finished");
      pinsIn.earthFaultInput <= 1'b1;
      pinsIn.channelOne <= 1'b1;
      tick(10);
      check({outsSeen.instEnable, outsSeen.supplyFaultOutput}, 2'b00, "earth fault");
      pinsIn.earthFaultInput <= 1'b0;
      tick(10);
      check({outsSeen.instEnable, outsSeen.supplyFaultOutput}, 2'b11, "fault gone");
      pinsIn.supplyPresent <= 1'b0;
      tick(10);
      check({outsSeen.supplyIndicator, outsSeen.supplyFaultOutput, outsSeen.instEnable}, 3'h0, "supply lost");
      pinsIn.supplyPresent <= 1'b1;
      injectFault <= 1'b1;
      tick(10);
      check(outsSeen.supplyFaultOutput, 0, "expansion fault");
      injectFault <= 1'b0;
      apb(1, CTRL_OFS, 32'h1, rd, er);
      pinsIn.channelTwo <= 1'b1;
      tick(10);
      check({outsSeen.instEnable, outsSeen.channelOneIndicator, outsSeen.channelTwoIndicator}, 3'h7, "dual active");
      pinsIn.crossShortTestA <= 1'b1;
      tick(10);
      check({outsSeen.supplyIndicator, outsSeen.channelOneIndicator, outsSeen.channelTwoIndicator,
             outsSeen.instEnable, outsSeen.delayEnable, outsSeen.faultIndicator}, 6'h01, "cross short");
      pinsIn.crossShortTestA <= 1'b0;
      tick(10);
      check({outsSeen.faultIndicator, outsSeen.supplyFaultOutput}, 2'b10, "fuse latched");
      $display("Test faults finished");
      nrst <= 1'b0;
      tick(2);
      check(32'(outsSeen), 0, "outputs in reset");
      nrst <= 1'b1;
      apb(0, CTRL_OFS, 0, rd, er);
      check(rd, 32'h4, "control after reset");
      $display("Test second reset finished");
      conclude();
   end

endmodule : safety_start_delay_controller_bench

`default_nettype wire
